// *** design/brts_pkg.sv ***
// package for the block register transfer sequencer
// Behaviour
// - execute only when condition passes; otherwise report not executed
// - bit i of the 16-bit list selects register i
// - ascending register order, lowest register at lowest address, pc last
// - addresses from base, before/after and up/down bits; direction 1 loads
// - without write-back base keeps value unless loaded from list
// - stored program counter equals instruction address plus 12
// - low two base address bits pass through to the address outputs
// - privileged load with pc copies saved status with the pc load
// - privileged store reads the user-mode bank
// - privileged load without pc writes the user-mode bank
// - base written back at end of cycle two; later stores see new base
// - loaded base value replaces the written-back base unless a load abort occurs
// - store abort completes transfers then traps; only base write-back
// - load abort suppresses aborting and later register writes
// - after load abort base restored, modified value if write-back requested
// - load abort trap taken only after whole sequence ends
// - load takes n+2 cycles, n+4 when pc is loaded
// - store takes n+1 cycles
package brts_pkg;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_XCNT = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ABORT_BIT = 1;
  localparam int STAT_STATE_LSB = 4;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [31:0] PC_STORE_OFS = 32'h0000000C;
  localparam logic [31:0] WORD_STEP = 32'h00000004;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_XFER = 3'b010,
    ST_INTL = 3'b011,
    ST_FILL1 = 3'b100,
    ST_FILL2 = 3'b101
  } brts_state_t;

  typedef struct packed {
    logic cond_pass;
    logic load;
    logic pre;
    logic up;
    logic wb;
    logic priv;
    logic [3:0] base_idx;
    logic [15:0] reg_list;
    logic [31:0] base_val;
    logic [31:0] instr_addr;
  } brts_instr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic seq;
    logic [31:0] addr;
    logic [31:0] wdata;
  } brts_mem_t;

  typedef struct packed {
    logic we;
    logic user_bank;
    logic [3:0] idx;
    logic [31:0] data;
  } brts_rfw_t;

endpackage

// *** design/brts_seq.sv ***
// block register transfer sequencer
`timescale 1ns/10ps
module brts_seq import brts_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // instruction issue
  input wire logic start,
  input wire brts_instr_t instr,
  output logic busy,
  output logic done,
  output logic skipped,
  output logic abort_trap,
  // register bank
  output logic [3:0] rd_idx,
  output logic rd_user_bank,
  input wire logic [31:0] rd_data,
  output brts_rfw_t rf_wr,
  output logic psr_restore,
  // memory
  output brts_mem_t mem,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort,
  // register port
  input wire logic [3:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [31:0] bus_rdata
);

  brts_state_t state_ff, nxt_state;
  brts_instr_t ins_ff;
  brts_mem_t mem_ff, nxt_mem;
  brts_rfw_t rfw_ff, nxt_rfw;
  logic psr_ff, nxt_psr;
  logic [15:0] rem_ff;
  logic [3:0] cur_idx_ff;
  logic abort_ff;
  logic en_ff;
  logic last_abort_ff;
  logic [31:0] xcnt_ff;
  logic [31:0] rdata_ff;
  logic [31:0] cyc_ff;
  logic [4:0] run_cnt [0:16];
  logic [3:0] low_idx;
  logic [31:0] n_bytes;
  logic [31:0] wb_val;
  logic [31:0] start_addr;
  logic [31:0] st_data;
  logic [15:0] low_mask;

  // register count by running sum
  assign run_cnt[0] = 5'h00;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cnt
      assign run_cnt[gi + 1] = run_cnt[gi] + {4'h0, ins_ff.reg_list[gi]};
    end
  endgenerate

  // lowest remaining register
  always_comb begin
    low_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (rem_ff[i]) begin
        low_idx = 4'(i);
      end
    end
  end

  // address arithmetic
  wire in_idle = (state_ff == ST_IDLE);
  wire in_setup = (state_ff == ST_SETUP);
  wire in_xfer = (state_ff == ST_XFER);
  wire in_intl = (state_ff == ST_INTL);
  wire in_fill2 = (state_ff == ST_FILL2);
  wire pc_listed = ins_ff.reg_list[PC_IDX];
  wire is_load = ins_ff.load;
  wire user_bank = ins_ff.priv & (~is_load | ~pc_listed);
  wire rem_empty = (rem_ff == 16'h0000);
  wire issue = in_setup | (in_xfer & ~rem_empty);
  wire last_xfer = in_xfer & rem_empty;
  wire xfer_abort = in_xfer & mem_ff.valid & mem_abort;
  wire ab_now = abort_ff | xfer_abort;
  wire accept = in_idle & start & en_ff;
  wire pc_fill = pc_listed & ~abort_ff;

  assign low_mask = 16'h0001 << low_idx;
  assign n_bytes = {25'h0000000, run_cnt[16], 2'b00};
  assign wb_val = ins_ff.up ? ins_ff.base_val + n_bytes : ins_ff.base_val - n_bytes;
  assign start_addr = ins_ff.up ?
    (ins_ff.pre ? ins_ff.base_val + WORD_STEP : ins_ff.base_val) :
    (ins_ff.pre ? ins_ff.base_val - n_bytes : ins_ff.base_val - n_bytes + WORD_STEP);

  // store data selection
  wire store_pc = (low_idx == PC_IDX);
  wire store_new_base = in_xfer & ins_ff.wb & (low_idx == ins_ff.base_idx);
  assign st_data = store_pc ? ins_ff.instr_addr + PC_STORE_OFS :
    (store_new_base ? wb_val : rd_data);

  // next memory request
  always_comb begin
    nxt_mem = '0;
    if (issue) begin
      nxt_mem.valid = 1'b1;
      nxt_mem.write = ~is_load;
      nxt_mem.seq = in_xfer;
      nxt_mem.addr = in_setup ? start_addr : mem_ff.addr + WORD_STEP;
      nxt_mem.wdata = is_load ? 32'h00000000 : st_data;
    end
  end

  // next register bank write
  always_comb begin
    nxt_rfw = '0;
    nxt_rfw.user_bank = user_bank;
    nxt_psr = 1'b0;
    if (in_setup & ins_ff.wb) begin
      nxt_rfw.we = 1'b1;
      nxt_rfw.idx = ins_ff.base_idx;
      nxt_rfw.data = wb_val;
    end else if (in_xfer & is_load & ~ab_now) begin
      nxt_rfw.we = 1'b1;
      nxt_rfw.idx = cur_idx_ff;
      nxt_rfw.data = mem_rdata;
      nxt_psr = ins_ff.priv & (cur_idx_ff == PC_IDX);
    end else if (last_xfer & is_load & ab_now) begin
      nxt_rfw.we = 1'b1;
      nxt_rfw.idx = ins_ff.base_idx;
      nxt_rfw.data = ins_ff.wb ? wb_val : ins_ff.base_val;
    end
  end

  // sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept & instr.cond_pass) begin
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        nxt_state = ST_XFER;
      end
      ST_XFER: begin
        if (rem_empty) begin
          nxt_state = is_load ? ST_INTL : ST_IDLE;
        end
      end
      ST_INTL: begin
        nxt_state = pc_fill ? ST_FILL1 : ST_IDLE;
      end
      ST_FILL1: begin
        nxt_state = ST_FILL2;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // handshake outputs
  assign busy = ~in_idle;
  assign skipped = accept & ~instr.cond_pass;
  assign done = (last_xfer & ~is_load) | (in_intl & ~pc_fill) | in_fill2;
  assign abort_trap = done & ab_now;
  assign rd_idx = low_idx;
  assign rd_user_bank = user_bank;
  assign rf_wr = rfw_ff;
  assign psr_restore = psr_ff;
  assign mem = mem_ff;
  assign bus_rdata = rdata_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      mem_ff <= '0;
      rfw_ff <= '0;
      psr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mem_ff <= nxt_mem;
      rfw_ff <= nxt_rfw;
      psr_ff <= nxt_psr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ins_ff <= '0;
      rem_ff <= 16'h0000;
      cur_idx_ff <= 4'h0;
      abort_ff <= 1'b0;
    end else if (accept) begin
      ins_ff <= instr;
      rem_ff <= instr.reg_list;
      abort_ff <= 1'b0;
    end else begin
      if (issue) begin
        rem_ff <= rem_ff & ~low_mask;
        cur_idx_ff <= low_idx;
      end
      if (xfer_abort) begin
        abort_ff <= 1'b1;
      end
    end
  end

  // cycle count of the running instruction
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cyc_ff <= 32'h00000000;
    end else if (in_idle) begin
      cyc_ff <= 32'h00000000;
    end else begin
      cyc_ff <= cyc_ff + 32'h00000001;
    end
  end

  // register port
  wire sel_ctrl = (bus_addr == REG_CTRL);
  wire sel_stat = (bus_addr == REG_STAT);
  wire sel_xcnt = (bus_addr == REG_XCNT);
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[STAT_BUSY_BIT] = busy;
    stat_word[STAT_ABORT_BIT] = last_abort_ff;
    stat_word[STAT_STATE_LSB +: 3] = state_ff;
  end
  wire [31:0] rd_mux = sel_ctrl ? {31'h00000000, en_ff} :
    sel_stat ? stat_word :
    sel_xcnt ? xcnt_ff : 32'h00000000;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      en_ff <= CTRL_EN_RESET;
      last_abort_ff <= 1'b0;
      xcnt_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
    end else begin
      if (bus_we && sel_ctrl) begin
        en_ff <= bus_wdata[CTRL_EN_BIT];
      end
      if (done) begin
        last_abort_ff <= ab_now;
        xcnt_ff <= xcnt_ff + 32'h00000001;
      end
      rdata_ff <= bus_re ? rd_mux : 32'h00000000;
    end
  end

  // checks
  logic [3:0] prev_idx_ff;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev_idx_ff <= 4'h0;
    end else if (mem_ff.valid) begin
      prev_idx_ff <= cur_idx_ff;
    end
  end
  wire [4:0] n_regs = run_cnt[16];

  property p_skip;
    @(posedge ref_clk) disable iff (!resetn)
    skipped |=> in_idle && !mem_ff.valid;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction started");

  property p_order;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && mem_ff.seq |-> cur_idx_ff > prev_idx_ff;
  endproperty
  a_order: assert property (p_order) else $error("registers out of order");

  property p_step;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && mem_ff.seq |-> mem_ff.addr == $past(mem_ff.addr) + WORD_STEP;
  endproperty
  a_step: assert property (p_step) else $error("address step not four");

  property p_pc_store;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && mem_ff.write && cur_idx_ff == PC_IDX
      |-> mem_ff.wdata == ins_ff.instr_addr + PC_STORE_OFS;
  endproperty
  a_pc_store: assert property (p_pc_store) else $error("stored pc wrong");

  property p_wb_time;
    @(posedge ref_clk) disable iff (!resetn)
    in_setup && ins_ff.wb |=> rfw_ff.we && rfw_ff.idx == ins_ff.base_idx
      && rfw_ff.data == wb_val;
  endproperty
  a_wb_time: assert property (p_wb_time) else $error("base write-back late");

  property p_abort_load;
    @(posedge ref_clk) disable iff (!resetn)
    abort_ff && is_load && rfw_ff.we |-> rfw_ff.idx == ins_ff.base_idx && !psr_ff;
  endproperty
  a_abort_load: assert property (p_abort_load) else $error("write after abort");

  property p_psr;
    @(posedge ref_clk) disable iff (!resetn)
    psr_ff |-> rfw_ff.we && rfw_ff.idx == PC_IDX && ins_ff.priv;
  endproperty
  a_psr: assert property (p_psr) else $error("status restore apart from pc");

  property p_trap;
    @(posedge ref_clk) disable iff (!resetn)
    abort_trap |-> done ##1 in_idle;
  endproperty
  a_trap: assert property (p_trap) else $error("trap before end");

  property p_store_len;
    @(posedge ref_clk) disable iff (!resetn)
    done && !is_load |-> cyc_ff == {27'h0000000, n_regs};
  endproperty
  a_store_len: assert property (p_store_len) else $error("store cycle count");

  property p_load_len;
    @(posedge ref_clk) disable iff (!resetn)
    done && is_load |-> cyc_ff == {27'h0000000, n_regs}
      + (pc_fill ? 32'h00000003 : 32'h00000001);
  endproperty
  a_load_len: assert property (p_load_len) else $error("load cycle count");

  property p_pc_last;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && cur_idx_ff == PC_IDX |-> rem_empty;
  endproperty
  a_pc_last: assert property (p_pc_last) else $error("pc not transferred last");

  property p_low_bits;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid |-> mem_ff.addr[1:0] == ins_ff.base_val[1:0];
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low address bits lost");

  property p_store_base;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && mem_ff.write && mem_ff.seq && ins_ff.wb
      && cur_idx_ff == ins_ff.base_idx |-> mem_ff.wdata == wb_val;
  endproperty
  a_store_base: assert property (p_store_base) else $error("later base store old");

  property p_store_first;
    @(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && mem_ff.write && !mem_ff.seq && cur_idx_ff != PC_IDX
      |-> mem_ff.wdata == $past(rd_data);
  endproperty
  a_store_first: assert property (p_store_first) else $error("first store data");

  property p_store_quiet;
    @(posedge ref_clk) disable iff (!resetn)
    abort_ff && !is_load |-> !rfw_ff.we && !psr_ff;
  endproperty
  a_store_quiet: assert property (p_store_quiet) else $error("state change on store abort");

  property p_store_end;
    @(posedge ref_clk) disable iff (!resetn)
    done && !is_load |-> mem_ff.valid && rem_empty;
  endproperty
  a_store_end: assert property (p_store_end) else $error("store ended early");

  property p_psr_pc;
    @(posedge ref_clk) disable iff (!resetn)
    rfw_ff.we && rfw_ff.idx == PC_IDX && is_load && ins_ff.priv && !abort_ff |-> psr_ff;
  endproperty
  a_psr_pc: assert property (p_psr_pc) else $error("status not restored with pc");

  c_store: cover property (@(posedge ref_clk) disable iff (!resetn) done && !is_load);
  c_load_pc: cover property (@(posedge ref_clk) disable iff (!resetn) in_fill2);
  c_load_abort: cover property (@(posedge ref_clk) disable iff (!resetn)
    abort_trap && is_load);
  c_user_bank: cover property (@(posedge ref_clk) disable iff (!resetn)
    mem_ff.valid && user_bank);

endmodule

// *** tb/brts_mem_model.sv ***
// memory system and memory manager partner model
`timescale 1ns/10ps
module brts_mem_model import brts_pkg::*; (
  // clock
  input wire logic ref_clk,
  // memory side
  input wire brts_mem_t mem,
  output logic [31:0] mem_rdata,
  output logic mem_abort,
  // abort control
  input wire logic [31:0] abort_addr,
  input wire logic abort_en
);
  logic [31:0] junk_ff = 32'h0;
  always_ff @(posedge ref_clk) begin
    junk_ff <= junk_ff + 32'h9E37;
  end
  // no storage, so aborted writes never land
  assign mem_rdata = (mem.valid && !mem.write) ? {mem.addr[15:0], ~mem.addr[15:0]} : junk_ff;
  assign mem_abort = mem.valid && abort_en && (mem.addr == abort_addr);
endmodule

// *** tb/brts_seq_test.sv ***
// self-checking bench for the block register transfer sequencer
`timescale 1ns/10ps
module brts_seq_test import brts_pkg::*;;
  logic ref_clk = 0, resetn = 0, start = 0, bus_we = 0, bus_re = 0, abort_en = 0;
  brts_instr_t instr = '0;
  logic [3:0] bus_addr = 4'h0, rd_idx;
  logic [31:0] bus_wdata = 32'h0, abort_addr = 32'h0, rd_data, mem_rdata, bus_rdata;
  logic busy, done, skipped, abort_trap, rd_user_bank, psr_restore, mem_abort;
  brts_rfw_t rf_wr;
  brts_mem_t mem;
  int n_fail = 0, checks_done = 0, n_done = 0, seed;
  logic [65:0] qm[$];
  logic [37:0] qr[$];
  logic [65:0] em;
  logic [37:0] er;

  brts_seq dut (.ref_clk, .resetn, .start, .instr, .busy, .done, .skipped, .abort_trap,
    .rd_idx, .rd_user_bank, .rd_data, .rf_wr, .psr_restore, .mem, .mem_rdata, .mem_abort,
    .bus_addr, .bus_wdata, .bus_we, .bus_re, .bus_rdata);
  brts_mem_model mm (.ref_clk, .mem, .mem_rdata, .mem_abort, .abort_addr, .abort_en);

  assign rd_data = {7'h50, rd_user_bank, 20'h0, rd_idx};

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(string nm, logic [38:0] seen, logic [38:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(negedge ref_clk) begin
    if (resetn && mem.valid) begin
      em = qm.size() ? qm.pop_front() : 'x;
      check("mem addr", {mem.seq, mem.write, mem.addr}, em[65:32]);
      if (mem.write) check("mem data", mem.wdata, em[31:0]);
    end
    if (resetn && (rf_wr.we || psr_restore)) begin
      er = qr.size() ? qr.pop_front() : 'x;
      check("reg write", {psr_restore, rf_wr}, {er[37], 1'b1, er[36:0]});
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic bus(logic re, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    bus_re <= re;
    bus_we <= !re;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_re <= 0;
    bus_we <= 0;
    @(negedge ref_clk);
    if (re) check("bus read", bus_rdata, d);
  endtask

  task automatic run(logic ld, pr, up, wb, pv, logic [15:0] lst, logic [31:0] b, int ab);
    int n, k, c, x;
    logic [31:0] a, w, d;
    logic abd, u, fst;
    n = $countones(lst);
    w = up ? b + 4 * n : b - 4 * n;
    a = up ? b + (pr ? 4 : 0) : b - 4 * n + (pr ? 0 : 4);
    u = pv && (!ld || !lst[15]);
    abd = 0;
    k = 0;
    fst = 1;
    abort_en <= ab < 16;
    abort_addr <= a + 4 * ab;
    if (wb) qr.push_back({2'b0, 4'h3, w});
    for (int i = 0; i < 16; i++) begin
      if (lst[i]) begin
        d = i == 15 ? 32'h800C : (i == 3 && wb && !fst) ? w : {7'h50, u, 20'h0, 4'(i)};
        qm.push_back({k > 0, !ld, a, d});
        if (k == ab) abd = 1;
        if (ld && !abd) qr.push_back({pv && i == 15, u, 4'(i), a[15:0], ~a[15:0]});
        a += 4;
        k++;
        fst = 0;
      end
    end
    if (ld && abd) qr.push_back({2'b0, 4'h3, wb ? w : b});
    x = ld ? ((lst[15] && !abd) ? n + 4 : n + 2) : n + 1;
    @(posedge ref_clk);
    start <= 1;
    instr <= '{1'b1, ld, pr, up, wb, pv, 4'h3, lst, b, 32'h8000};
    @(posedge ref_clk);
    start <= 0;
    c = 0;
    while (c < 40) begin
      @(negedge ref_clk);
      c++;
      if (done === 1'b1) break;
    end
    check("cycles", c, x);
    check("trap", abort_trap, abd);
    if (c == 40) begin
      n_fail++;
      end_of_test;
    end
    n_done++;
    @(negedge ref_clk);
    check("pending", qm.size() + qr.size(), 0);
  endtask

  initial begin
    seed = $urandom(32'hF9FE);
    repeat (12) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    start <= 1;
    instr.reg_list <= 16'h0001;
    @(negedge ref_clk);
    check("skip", {skipped, busy}, 2'b10);
    @(posedge ref_clk);
    start <= 0;
    for (int m = 0; m < 8; m++) begin
      run(m[2], m[1], m[0], 1, 0, 16'h80A2, 32'h1000, 16);
    end
    run(0, 0, 1, 1, 0, 16'h8018, 32'h2001, 16);
    run(0, 1, 0, 1, 0, 16'h002C, 32'h2002, 16);
    run(1, 0, 1, 0, 0, 16'h000C, 32'h3000, 16);
    run(1, 0, 1, 0, 1, 16'h8001, 32'h3100, 16);
    run(1, 1, 0, 0, 1, 16'h00F0, 32'h3200, 16);
    run(0, 0, 1, 0, 1, 16'h8010, 32'h3300, 16);
    run(0, 0, 1, 1, 0, 16'h000E, 32'h3400, 1);
    bus(1, 4'h4, 32'h2);
    run(1, 0, 1, 1, 0, 16'h801A, 32'h3500, 2);
    run(1, 1, 0, 0, 0, 16'h800C, 32'h3600, 0);
    repeat (8) begin
      run($urandom, $urandom, $urandom, $urandom, 0, 16'($urandom) | 16'h0400,
        32'h5000 + ($urandom & 32'hFF3), 16);
    end
    bus(0, 4'h0, 32'h0);
    @(posedge ref_clk);
    start <= 1;
    instr.cond_pass <= 1;
    @(posedge ref_clk);
    start <= 0;
    @(negedge ref_clk);
    check("disabled", busy, 0);
    bus(0, 4'h0, 32'h1);
    bus(1, 4'h0, 32'h1);
    bus(1, 4'h8, 32'(n_done));
    bus(1, 4'hC, 32'h0);
    end_of_test;
  end
endmodule
